// file: dfo_pkg.sv
// Constants and types for the decrement file register execute block.
// Operation
// - Opcode bits 15:10 equal 000001; bit 9 destination, bit 8 bank, bits 7:0 address.
// - Subtract one from the file register; destination 0 is working register, 1 file.
// - Update carry, digit carry, negative, overflow and zero; keep other status bits.
// - Bank bit 0 uses the access bank; 1 uses the bank number register as upper bits.
// - Extended set, bank bit 0 and address at most 95 select indexed literal offset.
package dfo_pkg;
  localparam logic [5:0] DFO_OPCODE = 6'h01;
  localparam int DFO_OP_HI = 15;
  localparam int DFO_OP_LO = 10;
  localparam int DFO_DEST_BIT = 9;
  localparam int DFO_BANK_BIT = 8;
  localparam int DFO_FILE_HI = 7;
  localparam int DFO_FILE_LO = 0;
  localparam logic [7:0] DFO_INDEX_LIMIT = 8'h5F;
  localparam logic [7:0] DFO_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] DFO_SFR_BANK = 4'hF;
  localparam logic [3:0] DFO_LOW_BANK = 4'h0;
  localparam logic [7:0] DFO_ONE = 8'h01;
  localparam int DFO_C = 0;
  localparam int DFO_DIGIT_CARRY = 1;
  localparam int DFO_Z = 2;
  localparam int DFO_OVERFLOW = 3;
  localparam int DFO_N = 4;
  typedef enum logic [1:0]
  {
    DFO_PH_DECODE = 2'b00,
    DFO_PH_READ = 2'b01,
    DFO_PH_PROCESS = 2'b11,
    DFO_PH_WRITE = 2'b10
  } dfo_phase_t;
endpackage

// file: dfo_decrement_file_op.sv
// Decode and execute logic for the decrement file register instruction.
module dfo_decrement_file_op
  import dfo_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Instruction and core state.
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_number_register_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] status_i,
  // Data memory.
  output logic [11:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_rdata_i,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  // Working register and status.
  output logic w_wr_o,
  output logic [7:0] w_data_o,
  output logic status_wr_o,
  output logic [7:0] status_o,
  output logic busy_o
);
  import dfo_pkg::*;

  // ----------------------------------------
  // Declarations.
  // ----------------------------------------
  dfo_phase_t phase_reg;
  logic active_reg;
  logic dest_reg;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [7:0] status_reg;
  logic hit;
  logic take;
  logic dest_sel;
  logic bank_sel;
  logic [7:0] file_addr;
  logic in_index_window;
  logic use_index;
  logic use_low_bank;
  logic [12:0] idx_sum;
  logic [7:0] f;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic carry_flag;
  logic digit_carry_flag;
  logic negative_flag;
  logic zero_flag;
  logic overflow_flag;
  logic [7:0] st_next;
  logic read_phase;
  logic write_phase;

  // ----------------------------------------
  // Instruction decode.
  // ----------------------------------------
  assign hit = instr_valid_i && instr_i[DFO_OP_HI:DFO_OP_LO] == DFO_OPCODE;
  assign take = hit && phase_reg == DFO_PH_DECODE;
  assign dest_sel = instr_i[DFO_DEST_BIT];
  assign bank_sel = instr_i[DFO_BANK_BIT];
  assign file_addr = instr_i[DFO_FILE_HI:DFO_FILE_LO];
  assign in_index_window = file_addr <= DFO_INDEX_LIMIT;
  assign use_index = ext_set_en_i && !bank_sel && in_index_window;
  assign use_low_bank = file_addr < DFO_ACCESS_SPLIT;
  assign idx_sum = {1'b0, index_base_i} + {5'h00, file_addr};

  // ----------------------------------------
  // Phase sequencer.
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_reg <= DFO_PH_DECODE;
    end
    else
    begin
      unique case (phase_reg)
        DFO_PH_DECODE:
        begin
          if (take)
          begin
            phase_reg <= DFO_PH_READ;
          end
        end
        DFO_PH_READ:
        begin
          phase_reg <= DFO_PH_PROCESS;
        end
        DFO_PH_PROCESS:
        begin
          phase_reg <= DFO_PH_WRITE;
        end
        DFO_PH_WRITE:
        begin
          phase_reg <= DFO_PH_DECODE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Busy flag.
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      active_reg <= 1'b0;
    end
    else if (take)
    begin
      active_reg <= 1'b1;
    end
    else if (write_phase)
    begin
      active_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Operand address selection.
  // ----------------------------------------
  always_comb
  begin
    if (bank_sel)
    begin
      addr_next = {bank_number_register_i, file_addr};
    end
    else if (use_index)
    begin
      addr_next = idx_sum[11:0];
    end
    else if (use_low_bank)
    begin
      addr_next = {DFO_LOW_BANK, file_addr};
    end
    else
    begin
      addr_next = {DFO_SFR_BANK, file_addr};
    end
  end

  // ----------------------------------------
  // Operand capture.
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr_reg <= 12'h000;
    end
    else if (take)
    begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dest_reg <= 1'b0;
    end
    else if (take)
    begin
      dest_reg <= dest_sel;
    end
  end

  // ----------------------------------------
  // Arithmetic.
  // ----------------------------------------
  assign f = mem_rdata_i;
  assign diff = {1'b0, f} - {1'b0, DFO_ONE};
  assign low_diff = {1'b0, f[3:0]} - {1'b0, DFO_ONE[3:0]};
  assign result_next = diff[7:0];
  assign carry_flag = ~diff[8];
  assign digit_carry_flag = ~low_diff[4];
  assign negative_flag = diff[7];
  assign zero_flag = diff[7:0] == 8'h00;
  assign overflow_flag = f[7] & ~diff[7];

  // ----------------------------------------
  // Status merge.
  // ----------------------------------------
  always_comb
  begin
    st_next = status_i;
    st_next[DFO_C] = carry_flag;
    st_next[DFO_DIGIT_CARRY] = digit_carry_flag;
    st_next[DFO_N] = negative_flag;
    st_next[DFO_Z] = zero_flag;
    st_next[DFO_OVERFLOW] = overflow_flag;
  end

  // ----------------------------------------
  // Result registers.
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_reg <= 8'h00;
    end
    else if (read_phase)
    begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_reg <= 8'h00;
    end
    else if (read_phase)
    begin
      status_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  assign read_phase = phase_reg == DFO_PH_READ;
  assign write_phase = phase_reg == DFO_PH_WRITE;
  assign mem_addr_o = addr_reg;
  assign mem_rd_o = read_phase;
  assign mem_wdata_o = result_reg;
  assign w_data_o = result_reg;
  assign status_o = status_reg;
  assign mem_wr_o = write_phase && dest_reg;
  assign w_wr_o = write_phase && !dest_reg;
  assign status_wr_o = write_phase;
  assign busy_o = active_reg;
endmodule

// file: dfo_sva.sv
// Assertions for the decrement file register block.
module dfo_sva
  import dfo_pkg::*;
(
  input wire logic clk_sys_i, resetn_i, instr_valid_i, ext_set_en_i, mem_rd_o, mem_wr_o, w_wr_o,
  input wire logic status_wr_o, busy_o,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] bank_number_register_i,
  input wire logic [11:0] index_base_i, mem_addr_o,
  input wire logic [7:0] status_i, mem_rdata_i, mem_wdata_o, status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire logic hit = instr_valid_i && !busy_o && instr_i[15:10] == DFO_OPCODE;
  a_take_read: assert property (hit |=> mem_rd_o && busy_o) else $error("no read after take");
  a_ignore_other: assert property (instr_valid_i && !busy_o && instr_i[15:10] != DFO_OPCODE |=> !mem_rd_o)
    else $error("foreign opcode taken");
  a_dest_select: assert property (hit |-> ##3 status_wr_o && mem_wr_o == $past(instr_i[9], 3) && w_wr_o != mem_wr_o)
    else $error("wrong destination strobe");
  a_result_value: assert property (mem_rd_o |-> ##2 mem_wdata_o == $past(mem_rdata_i, 2) - 8'h01)
    else $error("wrong result");
  a_status_flags: assert property (status_wr_o |-> status_o[7:5] == $past(status_i[7:5], 2)
    && status_o[DFO_Z] == ($past(mem_rdata_i, 2) == 8'h01)) else $error("wrong status");
  a_carry_flag: assert property (status_wr_o |-> status_o[DFO_C] == ($past(mem_rdata_i, 2) != 8'h00))
    else $error("wrong carry flag");
  a_bank_addr: assert property (mem_rd_o && $past(instr_i[8])
    |-> mem_addr_o == {$past(bank_number_register_i), $past(instr_i[7:0])}) else $error("wrong bank address");
  a_index_addr: assert property (mem_rd_o && $past(ext_set_en_i && !instr_i[8] && instr_i[7:0] <= 8'h5F)
    |-> mem_addr_o == $past(index_base_i) + $past(instr_i[7:0])) else $error("wrong indexed address");
  c_file_write: cover property (mem_wr_o);
  c_w_write: cover property (w_wr_o);
  c_indexed: cover property (hit && ext_set_en_i && instr_i[7:0] < 8'h60);
endmodule

// file: tb_top.sv
// Self-checking bench for the decrement file register block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dfo_pkg::*;
  logic clk_sys_i = 0, resetn_i = 0, instr_valid_i = 0, ext_set_en_i = 0;
  logic [15:0] instr_i = 16'h0000;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [11:0] mem_addr_o;
  logic [7:0] mem_wdata_o, w_data_o, status_o;
  logic mem_rd_o, mem_wr_o, w_wr_o, status_wr_o, busy_o;
  int failures = 0, comparisons = 0;
  typedef struct {logic [15:0] ins; logic ext; logic [7:0] rd; logic [11:0] adr; logic [7:0] res, st;} dfo_row_t;
  dfo_row_t rows [5] = '{'{16'h0701, 0, 8'h01, 12'h301, 8'h00, 8'hE7}, '{16'h0410, 0, 8'h00, 12'h010, 8'hFF, 8'hF0},
    '{16'h0480, 0, 8'h80, 12'hF80, 8'h7F, 8'hE9}, '{16'h045F, 1, 8'h20, 12'h182, 8'h1F, 8'hE1},
    '{16'h0660, 1, 8'h11, 12'hF60, 8'h10, 8'hE3}};
  dfo_decrement_file_op dfo_decrement_file_op_i (.clk_sys_i, .resetn_i, .instr_valid_i, .instr_i, .ext_set_en_i,
    .bank_number_register_i(4'h3), .index_base_i(12'h123), .status_i(8'hE0), .mem_addr_o, .mem_rd_o, .mem_rdata_i,
    .mem_wr_o, .mem_wdata_o, .w_wr_o, .w_data_o, .status_wr_o, .status_o, .busy_o);
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    chk("reset", {busy_o, mem_wr_o, w_wr_o, status_wr_o, status_o}, 16'h0000);
    $display("reset done");
    resetn_i <= 1;
    foreach (rows[k])
    begin
      @(posedge clk_sys_i);
      {instr_valid_i, instr_i, ext_set_en_i, mem_rdata_i} <= {1'b1, rows[k].ins, rows[k].ext, rows[k].rd};
      @(posedge clk_sys_i);
      instr_valid_i <= 0;
      @(negedge clk_sys_i);
      chk("addr", mem_addr_o, rows[k].adr);
      repeat (2) @(negedge clk_sys_i);
      chk("strobes", {mem_wr_o, w_wr_o, status_wr_o}, {rows[k].ins[9], !rows[k].ins[9], 1'b1});
      chk("result", rows[k].ins[9] ? mem_wdata_o : w_data_o, rows[k].res);
      chk("status", status_o, rows[k].st);
      $display("row %0d done", k);
    end
    @(posedge clk_sys_i);
    {instr_valid_i, instr_i} <= {1'b1, 16'h0801};
    repeat (2) @(negedge clk_sys_i);
    chk("foreign", {busy_o, mem_rd_o}, 16'h0000);
    $display("foreign opcode done");
    close_out();
  end
  initial
  begin
    #5000;
    failures++;
    close_out();
  end
endmodule
bind dfo_decrement_file_op dfo_sva dfo_sva_i (.*);
